// ===== pmt_trap_timer_cfg.sv
// top: trap 2 compare, activity routing, terminal count selects, APB slave
// assumes: APB master per AMBA; trap 1 compare and trap 2 address elsewhere
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pmt_trap_timer_cfg #(
  parameter int US_CYCLES   = pmt_pkg::CLK_MHZ,
  parameter int TICK_US     = pmt_pkg::US_PER_TICK
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // bus events
  input  wire pmt_pkg::pmt_io_t         ioAccess,
  input  wire logic [31:0]              trap2Addr,
  input  wire logic                     trap1Hit,
  input  wire logic                     nmbAccess,
  input  wire logic [1:0]               userActivity,
  input  wire logic                     slowedClockState,
  // results
  output logic                          trap2Smi,
  output logic                          throttleActivity,
  output logic [pmt_pkg::N_IDLE-1:0]    timerExpired,
  output logic                          stopClockState
);

  // refused at elaboration: prescalers need at least two counts
  if (US_CYCLES < 2) begin : gBadUs
    $error("pmt_trap_timer_cfg: US_CYCLES below 2");
  end
  if (TICK_US < 2) begin : gBadTick
    $error("pmt_trap_timer_cfg: TICK_US below 2");
  end

  localparam int UC_W = $clog2(US_CYCLES);
  localparam int TK_W = $clog2(TICK_US);

  typedef struct packed {
    logic [7:0]      trap2Det;
    logic [7:0]      monitor;
    logic [7:0]      stbySusp;
    logic [7:0]      user12;
    logic [7:0]      user3Stop;
    logic [31:0]     rdata;
    logic            trap2Hit;
    logic            throttleAct;
    logic            stopState;
    logic [UC_W-1:0] usCnt;
    logic            usTick;
    logic [TK_W-1:0] tkCnt;
    logic            tick;
  } pmt_top_t;

  pmt_top_t st;
  pmt_top_t next_st;

  // ==========================================================================
  // apb decode
  logic [9:0] wordIdx;
  logic       hitDet;
  logic       hitMon;
  logic       hitSs;
  logic       hitU12;
  logic       hitU3;
  logic       mapped;
  logic       wrEn;
  logic       setup;
  logic [7:0] rdByte;

  assign wordIdx = paddr[pmt_pkg::ADDR_W-1:2];
  assign hitDet  = wordIdx == pmt_pkg::IDX_TRAP2_DETECT;
  assign hitMon  = wordIdx == pmt_pkg::IDX_TRAP_MONITOR;
  assign hitSs   = wordIdx == pmt_pkg::IDX_STBY_SUSP_CNT;
  assign hitU12  = wordIdx == pmt_pkg::IDX_USER12_CNT;
  assign hitU3   = wordIdx == pmt_pkg::IDX_USER3_STOP;
  assign mapped  = hitDet | hitMon | hitSs | hitU12 | hitU3;
  assign setup   = psel && !penable;
  // read data is latched in setup so the access phase never waits
  assign wrEn    = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rdByte = 8'h00;
    unique case (1'b1)
      hitDet:  rdByte = st.trap2Det;
      hitMon:  rdByte = st.monitor;
      hitSs:   rdByte = st.stbySusp;
      hitU12:  rdByte = st.user12;
      hitU3:   rdByte = st.user3Stop;
      default: rdByte = 8'h00;
    endcase
  end

  // ==========================================================================
  // trap 2 compare
  logic [31:0] cmpMask;
  logic [2:0]  lowSel;
  logic        trap2Match;

  assign lowSel = st.trap2Det[pmt_pkg::B_LOWSEL_HI:pmt_pkg::B_LOWSEL_LO];

  always_comb begin
    cmpMask = 32'hFFFFFFFF;
    if (st.trap2Det[pmt_pkg::B_MASK_HIGH])
      cmpMask[31:16] = 16'h0000;
    if (st.trap2Det[pmt_pkg::B_MASK_MID])
      cmpMask[15:10] = 6'h00;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(lowSel)) cmpMask[i] = 1'b0;
    end
  end

  assign trap2Match = ioAccess.valid &&
                      ((ioAccess.addr ^ trap2Addr) & cmpMask) == 32'h0;

  // ==========================================================================
  // activity routing
  logic [3:0]                 t1Mon;
  logic [3:0]                 t2Mon;
  logic [pmt_pkg::N_IDLE-1:0] idleRestart;
  logic                       throttleEvt;

  assign t1Mon = st.monitor[pmt_pkg::B_MON_T1 +: 4];
  assign t2Mon = st.monitor[pmt_pkg::B_MON_T2 +: 4];

  // monitor nibbles run standby, suspend, user 1, throttle from msb down
  assign idleRestart[pmt_pkg::T_STANDBY] =
    (trap1Hit && t1Mon[3]) || (st.trap2Hit && t2Mon[3]);
  assign idleRestart[pmt_pkg::T_SUSPEND] =
    (trap1Hit && t1Mon[2]) || (st.trap2Hit && t2Mon[2]);
  assign idleRestart[pmt_pkg::T_USER1] =
    (trap1Hit && t1Mon[1]) || (st.trap2Hit && t2Mon[1]) ||
    (nmbAccess && st.trap2Det[pmt_pkg::B_NMB_USER1]);
  assign idleRestart[pmt_pkg::T_USER2] = userActivity[0];
  assign idleRestart[pmt_pkg::T_USER3] = userActivity[1];
  assign throttleEvt =
    (trap1Hit && t1Mon[0]) || (st.trap2Hit && t2Mon[0]) ||
    (nmbAccess && st.trap2Det[pmt_pkg::B_NMB_THROTTLE]);

  // ==========================================================================
  // terminal count selects
  logic [pmt_pkg::PERIOD_W-1:0] idleLimit [pmt_pkg::N_IDLE];
  logic [pmt_pkg::STOP_W-1:0]   stopLimit;
  logic [1:0]                   stopSel;

  // standby table starts one entry later and ends at 240 min
  assign idleLimit[pmt_pkg::T_STANDBY] =
    pmt_pkg::PERIOD_100MS[int'(st.stbySusp[7:4]) + 1];
  assign idleLimit[pmt_pkg::T_SUSPEND] =
    pmt_pkg::PERIOD_100MS[st.stbySusp[3:0]];
  assign idleLimit[pmt_pkg::T_USER1] =
    pmt_pkg::PERIOD_100MS[st.user12[7:4]];
  assign idleLimit[pmt_pkg::T_USER2] =
    pmt_pkg::PERIOD_100MS[st.user12[3:0]];
  assign idleLimit[pmt_pkg::T_USER3] =
    pmt_pkg::PERIOD_100MS[st.user3Stop[7:4]];
  assign stopSel   = st.user3Stop[pmt_pkg::B_STOP_HI:pmt_pkg::B_STOP_LO];
  assign stopLimit = pmt_pkg::STOP_DELAY_US[stopSel];

  // ==========================================================================
  // timers
  logic stopExpired;

  genvar g;
  generate
    for (g = 0; g < pmt_pkg::N_IDLE; g++) begin : gIdle
      pmt_idle_timer #(
        .W (pmt_pkg::PERIOD_W)
      ) uTimer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (st.tick),
        .restart (idleRestart[g]),
        .limit   (idleLimit[g]),
        .expired (timerExpired[g])
      );
    end
  endgenerate

  // held in restart outside the slowed state, so it times only that state
  pmt_idle_timer #(
    .W (pmt_pkg::STOP_W)
  ) uStopDelay (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (st.usTick),
    .restart (!slowedClockState),
    .limit   (stopLimit),
    .expired (stopExpired)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    // prescalers: microsecond tick, then 100 ms tick
    next_st.usTick = 1'b0;
    next_st.tick   = 1'b0;
    if (st.usCnt == UC_W'(US_CYCLES - 1)) begin
      next_st.usCnt  = '0;
      next_st.usTick = 1'b1;
    end else begin
      next_st.usCnt = st.usCnt + UC_W'(1);
    end
    if (st.usTick) begin
      if (st.tkCnt == TK_W'(TICK_US - 1)) begin
        next_st.tkCnt = '0;
        next_st.tick  = 1'b1;
      end else begin
        next_st.tkCnt = st.tkCnt + TK_W'(1);
      end
    end
    // bus events
    next_st.trap2Hit    = trap2Match;
    next_st.throttleAct = throttleEvt;
    if (!slowedClockState)
      next_st.stopState = 1'b0;
    else if (stopExpired)
      next_st.stopState = 1'b1;
    // register access
    if (setup) next_st.rdata = {24'h000000, rdByte};
    if (wrEn) begin
      if (hitDet)
        next_st.trap2Det  = pwdata[7:0] & pmt_pkg::WMASK_TRAP2;
      if (hitMon)
        next_st.monitor   = pwdata[7:0] & pmt_pkg::WMASK_FULL;
      if (hitSs)
        next_st.stbySusp  = pwdata[7:0] & pmt_pkg::WMASK_FULL;
      if (hitU12)
        next_st.user12    = pwdata[7:0] & pmt_pkg::WMASK_FULL;
      if (hitU3)
        next_st.user3Stop = pwdata[7:0] & pmt_pkg::WMASK_USER3;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) st <= '0;
    else       st <= next_st;
  end

  assign prdata           = st.rdata;
  assign trap2Smi         = st.trap2Hit;
  assign throttleActivity = st.throttleAct;
  assign stopClockState   = st.stopState;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_trap2_exact: assert property (
    ioAccess.valid && ioAccess.addr == trap2Addr |=> trap2Smi)
    else $error("exact trap 2 address gave no interrupt");

  chk_mask_upper: assert property (
    ioAccess.valid && st.trap2Det[pmt_pkg::B_MASK_HIGH] &&
    ioAccess.addr[15:0] == trap2Addr[15:0] |=> trap2Smi)
    else $error("upper address mask not applied");

  chk_mask_mid: assert property (
    ioAccess.valid && st.trap2Det[pmt_pkg::B_MASK_MID] &&
    ioAccess.addr[31:16] == trap2Addr[31:16] &&
    ioAccess.addr[9:0] == trap2Addr[9:0] |=> trap2Smi)
    else $error("middle address mask not applied");

  chk_no_mask_miss: assert property (
    ioAccess.valid && st.trap2Det == 8'h00 &&
    ioAccess.addr[0] != trap2Addr[0] |=> !trap2Smi)
    else $error("unmasked address mismatch still trapped");

  chk_low_seven: assert property (
    ioAccess.valid && lowSel == 3'h7 &&
    ioAccess.addr[31:7] == trap2Addr[31:7] |=> trap2Smi)
    else $error("seven low bits not masked");

  chk_nmb_user1: assert property (
    nmbAccess && st.trap2Det[pmt_pkg::B_NMB_USER1]
    |-> idleRestart[pmt_pkg::T_USER1])
    else $error("memory access did not restart user timer 1");

  chk_nmb_throttle: assert property (
    nmbAccess && st.trap2Det[pmt_pkg::B_NMB_THROTTLE] |=> throttleActivity)
    else $error("memory access gave no throttle activity");

  chk_trap1_standby: assert property (
    trap1Hit && st.monitor[7] |-> idleRestart[pmt_pkg::T_STANDBY])
    else $error("trap 1 did not restart standby timer");

  chk_trap2_suspend: assert property (
    trap2Smi && st.monitor[2] |-> idleRestart[pmt_pkg::T_SUSPEND])
    else $error("trap 2 did not restart suspend timer");

  chk_mon_off_quiet: assert property (
    st.monitor == 8'h00 && st.trap2Det == 8'h00 && !userActivity[0]
    |-> idleRestart[pmt_pkg::T_USER2] == 1'b0 &&
        idleRestart[pmt_pkg::T_STANDBY] == 1'b0)
    else $error("timer restarted with monitoring off");

  chk_standby_tbl: assert property (
    st.stbySusp[7:4] == 4'hF |-> idleLimit[pmt_pkg::T_STANDBY] == 18'h23280)
    else $error("standby 240 minute limit wrong");

  chk_stop_delay: assert property (
    $rose(stopClockState) |-> $past(slowedClockState) && $past(stopExpired))
    else $error("stop state entered without delay expiry");

  chk_reserved_zero: assert property (
    st.trap2Det[5] == 1'b0 && st.user3Stop[1:0] == 2'h0)
    else $error("reserved bit became set");

  cov_trap2_hit:   cover property (trap2Smi);
  cov_stop_enter:  cover property ($rose(stopClockState));
  cov_idle_expire: cover property (|timerExpired);
  cov_apb_write:   cover property (wrEn ##2 (setup && !pwrite));

endmodule : pmt_trap_timer_cfg

`default_nettype wire

// ===== pmt_pkg.sv
// package: register indices, field positions, reset values, period tables
// assumes: 100 MHz clk_sys; registers reached as 32-bit words over APB
//
// Summary of operation
// - Bit 7 of the trap 2 control register masks I/O bits 15..10 from the trap 2 compare.
// - Bit 6 of the trap 2 control register masks I/O bits 31..16 from the trap 2 compare.
// - Bits 4..2 give how many lowest address bits are masked, none at 000 up to seven at 111.
// - Bit 1 lets non-motherboard memory accesses count as activity for user timer 1.
// - Bit 0 lets non-motherboard memory accesses count as activity for the throttle timer.
// - Monitor bits 7..4 let trap 1 hits restart standby, suspend, user 1 and throttle timers.
// - Monitor bits 3..0 let trap 2 hits restart standby, suspend, user 1 and throttle timers.
// - The upper standby/suspend nibble picks a standby period from 0.4 s up to 240 min.
// - The lower standby/suspend nibble picks a suspend period from 0.2 s up to 120 min.
// - Bits 7..4 of the user 1/2 register pick user timer 1's period from the 0.2 s..120 min table.
// - Bits 3..0 of the user 1/2 register pick user timer 2's period from the same table.
// - Bits 7..4 of the user 3 register pick user timer 3's period from the same table.
// - Bits 3..2 of the user 3 register pick the slowed-to-stop clock delay: 430 us, 7 ms, 55 ms, 1 s.
// - An I/O access matching the trap 2 address after masking raises a management interrupt.

package pmt_pkg;

  // ==========================================================================
  // register indices and address width
  localparam logic [9:0]  IDX_TRAP2_DETECT  = 10'h05D;
  localparam logic [9:0]  IDX_TRAP_MONITOR  = 10'h05E;
  localparam logic [9:0]  IDX_STBY_SUSP_CNT = 10'h05F;
  localparam logic [9:0]  IDX_USER12_CNT    = 10'h060;
  localparam logic [9:0]  IDX_USER3_STOP    = 10'h061;
  localparam int          ADDR_W            = 12;
  localparam logic [7:0]  REG_RESET         = 8'h00;

  // ==========================================================================
  // writable bits per register; reserved bits stay zero
  localparam logic [7:0]  WMASK_TRAP2       = 8'hDF;
  localparam logic [7:0]  WMASK_FULL        = 8'hFF;
  localparam logic [7:0]  WMASK_USER3       = 8'hFC;

  // ==========================================================================
  // field positions
  localparam int          B_MASK_MID        = 7;
  localparam int          B_MASK_HIGH       = 6;
  localparam int          B_LOWSEL_HI       = 4;
  localparam int          B_LOWSEL_LO       = 2;
  localparam int          B_NMB_USER1       = 1;
  localparam int          B_NMB_THROTTLE    = 0;
  localparam int          B_MON_T1          = 4;
  localparam int          B_MON_T2          = 0;
  localparam int          B_STOP_HI         = 3;
  localparam int          B_STOP_LO         = 2;

  // timer slots: standby, suspend, user 1, user 2, user 3
  localparam int          N_IDLE            = 5;
  localparam int          T_STANDBY         = 0;
  localparam int          T_SUSPEND         = 1;
  localparam int          T_USER1           = 2;
  localparam int          T_USER2           = 3;
  localparam int          T_USER3           = 4;

  // ==========================================================================
  // timing
  localparam int          CLK_MHZ           = 100;
  localparam int          US_PER_TICK       = 100000;
  localparam int          PERIOD_W          = 18;
  localparam int          STOP_W            = 20;

  // idle periods in units of 100 ms; entry 16 is the standby-only 240 min
  localparam logic [PERIOD_W-1:0] PERIOD_100MS [17] = '{
    18'h00002, 18'h00004, 18'h0000A, 18'h00012,
    18'h00023, 18'h00046, 18'h0008C, 18'h00118,
    18'h00230, 18'h004B0, 18'h008E8, 18'h01194,
    18'h02328, 18'h04650, 18'h08CA0, 18'h11940,
    18'h23280};

  // slowed-to-stop delays in microseconds: 430, 7000, 55000, 1000000
  localparam logic [STOP_W-1:0] STOP_DELAY_US [4] = '{
    20'h001AE, 20'h01B58, 20'h0D6D8, 20'hF4240};

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } pmt_io_t;

endpackage : pmt_pkg

// ===== pmt_idle_timer.sv
// idle timer: counts ticks, restarts on activity, fires once per idle span
// assumes: tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none

module pmt_idle_timer #(
  parameter int W = 18
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  // refused at elaboration: a one-bit count cannot hold a limit
  if (W < 2) begin : gBadW
    $error("pmt_idle_timer: W too small");
  end

  typedef struct packed {
    logic [W-1:0] count;
    logic         done;
    logic         expired;
  } pmt_tmr_t;

  pmt_tmr_t st;
  pmt_tmr_t next_st;

  // ==========================================================================
  // counting
  always_comb begin
    next_st = st;
    next_st.expired = 1'b0;
    if (restart) begin
      next_st.count = '0;
      next_st.done  = 1'b0;
    end else if (tick && !st.done) begin
      // done holds the timer so expiry is signalled once per idle span
      if ((st.count + W'(1)) >= limit) begin
        next_st.count   = '0;
        next_st.done    = 1'b1;
        next_st.expired = 1'b1;
      end else begin
        next_st.count = st.count + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) st <= '0;
    else       st <= next_st;
  end

  assign expired = st.expired;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_expire_at_limit: assert property (
    !restart && tick && !st.done && (st.count + W'(1)) >= limit
    |=> expired && st.done)
    else $error("timer did not expire at its limit");

  chk_restart_clears: assert property (
    restart |=> !expired && st.count == '0 && !st.done)
    else $error("restart did not clear the timer");

  chk_single_shot: assert property (
    expired ##1 !restart [*2] |-> !expired)
    else $error("timer expired twice without restart");

endmodule : pmt_idle_timer

`default_nettype wire

// ===== pmt_trap_timer_cfg_tb.sv
// testbench: apb registers, trap 2 compare, activity, timers, stop delay
// assumes: shortened tick parameters, single clk_sys domain, no model
`timescale 1ns/1ps
`default_nettype none

module pmt_trap_timer_cfg_tb;
  // ==========================================================
  // signals and tables
  localparam int UC = 2;
  localparam int TU = 2;
  localparam int TK = UC * TU;
  localparam logic [11:0] RA [5] = '{12'h174, 12'h178, 12'h17C,
                                     12'h180, 12'h184};
  localparam logic [7:0]  WM [5] = '{8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFC};
  // trap 2 masking cases: control, address flip, hit
  localparam logic [7:0]  TC [10] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h1C,
                                      8'h1C, 8'h80, 8'h80, 8'h40, 8'h40};
  localparam logic [31:0] TD [10] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'h7F,
    32'h80, 32'hFC00, 32'h200, 32'hFFFF0000, 32'h8000};
  localparam logic        TH [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                                      1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  // expiry limits in ticks for codes 1,0,1,2,3 (standby one step up)
  localparam int          LT [5] = '{10, 2, 4, 10, 18};
  localparam int          SD [2] = '{430, 7000};
  logic                         clk_sys;
  logic                         rstn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [pmt_pkg::ADDR_W-1:0]   paddr;
  logic [31:0]                  pwdata;
  logic                         pready;
  logic                         pslverr;
  logic [31:0]                  prdata;
  pmt_pkg::pmt_io_t             ioAccess;
  logic [31:0]                  trap2Addr;
  logic                         trap1Hit;
  logic                         nmbAccess;
  logic [1:0]                   userActivity;
  logic                         slowedClockState;
  logic                         trap2Smi;
  logic                         throttleActivity;
  logic [pmt_pkg::N_IDLE-1:0]   timerExpired;
  logic                         stopClockState;
  int                           mismatches;
  int                           checked;

  pmt_trap_timer_cfg #(.US_CYCLES(UC), .TICK_US(TU)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .ioAccess(ioAccess),
    .trap2Addr(trap2Addr), .trap1Hit(trap1Hit), .nmbAccess(nmbAccess),
    .userActivity(userActivity), .slowedClockState(slowedClockState),
    .trap2Smi(trap2Smi), .throttleActivity(throttleActivity),
    .timerExpired(timerExpired), .stopClockState(stopClockState));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] x,
                       input logic [31:0] got);
    checked++;
    if (got !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, x, got);
    end
  endtask : check

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready === 1'h1) break;
    end
    if (i == 16) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, {24'h0, d}, r, e);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
                       input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    check("prdata", x, r);
    check("pslverr", 32'(xe), 32'(e));
  endtask : rdchk

  // one-cycle event, then settle lat edges after it was driven
  task automatic evt(input int k, input int lat, input logic [31:0] fl);
    @(posedge clk_sys);
    nmbAccess <= (k == 0);
    trap1Hit <= (k == 1);
    ioAccess <= '{valid: (k == 2), addr: trap2Addr ^ fl};
    @(posedge clk_sys);
    nmbAccess <= 1'h0;
    trap1Hit <= 1'h0;
    ioAccess.valid <= 1'h0;
    repeat (lat - 1) @(posedge clk_sys);
    #1;
  endtask : evt

  // hold one activity source and count expiry pulses of one timer
  task automatic hold(input int k, input int idx, output int cnt);
    cnt = 0;
    @(posedge clk_sys);
    nmbAccess <= (k == 0);
    trap1Hit <= (k == 1);
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      if (timerExpired[idx] === 1'h1) cnt++;
    end
    @(posedge clk_sys);
    nmbAccess <= 1'h0;
    trap1Hit <= 1'h0;
  endtask : hold

  // ==========================================================
  // main sequence
  initial begin
    int i;
    int j;
    int c;
    int first [5];
    int cnt [5];
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ioAccess = '0;
    trap2Addr = 32'hA5C31E5A;
    trap1Hit = 1'h0;
    nmbAccess = 1'h0;
    userActivity = 2'h0;
    slowedClockState = 1'h0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'h1;
    for (i = 0; i < 5; i++) begin
      rdchk(RA[i], 32'h0, 1'h0);
      wr(RA[i], 8'hFF);
      rdchk(RA[i], {24'h0, WM[i]}, 1'h0);
    end
    wr(12'h188, 8'hFF);
    rdchk(12'h188, 32'h0, 1'h1);
    $display("test registers done");
    wr(RA[1], 8'h00);
    for (i = 0; i < 10; i++) begin
      wr(RA[0], TC[i]);
      evt(2, 1, TD[i]);
      check("trap2Smi", 32'(TH[i]), 32'(trap2Smi));
    end
    $display("test trap compare done");
    for (i = 0; i < 6; i++) begin
      wr(RA[0], (i == 0) ? 8'h01 : 8'h00);
      wr(RA[1], (i == 2) ? 8'h10 : (i == 3) ? 8'hEF :
                (i == 4) ? 8'h01 : (i == 5) ? 8'hFE : 8'h00);
      evt(i / 2, (i < 4) ? 1 : 2, 32'h0);
      check("throttle", 32'(i % 2 == 0), 32'(throttleActivity));
    end
    $display("test throttle done");
    wr(RA[1], 8'hE0);
    wr(RA[2], 8'h10);
    wr(RA[3], 8'h12);
    wr(RA[4], 8'h30);
    @(posedge clk_sys);
    trap1Hit <= 1'h1;
    userActivity <= 2'h3;
    @(posedge clk_sys);
    trap1Hit <= 1'h0;
    userActivity <= 2'h0;
    first = '{default: 0};
    cnt = '{default: 0};
    for (c = 1; c <= 120; c++) begin
      @(posedge clk_sys);
      #1;
      for (j = 0; j < 5; j++) begin
        if (timerExpired[j] === 1'h1 && cnt[j] == 0) first[j] = c;
        if (timerExpired[j] === 1'h1) cnt[j]++;
      end
    end
    for (j = 0; j < 5; j++) begin
      check("expiry time", 32'h1, 32'(first[j] >= TK * (LT[j] - 1) &&
            first[j] <= TK * LT[j] + 4));
      check("expiry count", 32'h1, 32'(cnt[j]));
    end
    $display("test timers done");
    // suspend at four ticks: its expiry must land inside the hold window
    wr(RA[2], 8'h11);
    // nmb for user 1 with bit 1 set/clear, trap 1 for suspend
    for (i = 0; i < 4; i++) begin
      wr(RA[0], (i == 0) ? 8'h02 : 8'h00);
      wr(RA[1], (i == 2) ? 8'h40 : 8'h00);
      hold(i / 2, (i < 2) ? 2 : 1, c);
      check("restart", 32'(i % 2), 32'(c > 0));
    end
    $display("test activity done");
    for (j = 0; j < 2; j++) begin
      wr(RA[4], (j == 0) ? 8'h30 : 8'h34);
      @(posedge clk_sys);
      slowedClockState <= 1'h1;
      c = 0;
      while (stopClockState !== 1'h1 && c < 20000) begin
        @(posedge clk_sys);
        #1;
        c++;
      end
      check("stop delay", 32'h1, 32'(c >= UC * SD[j] - 4 &&
            c <= UC * SD[j] + 6));
      @(posedge clk_sys);
      slowedClockState <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("stop clear", 32'h0, 32'(stopClockState));
    end
    $display("test stop delay done");
    test_done();
  end
endmodule : pmt_trap_timer_cfg_tb

`default_nettype wire
